// ==== logic/isv_map_map.svh ====
`ifndef ISV_MAP_MAP_SVH
`define ISV_MAP_MAP_SVH
// ----------------------------------------
// address map
// ----------------------------------------
`define ISV_ADDR_W     12
`define ISV_BANK_MSB   11
`define ISV_BANK_LSB   7
`define ISV_IDX_MSB    6
`define ISV_IDX_LSB    2
`define ISV_SMR_BANK   5'h00
`define ISV_SVR_BANK   5'h01
`define ISV_IVR_OFF    12'h100
`define ISV_FVR_OFF    12'h104
`define ISV_ISR_OFF    12'h108
`define ISV_IPR_OFF    12'h10C
`define ISV_SPU_OFF    12'h134
`define ISV_EVT_OFF    12'h150
`define ISV_EVM_OFF    12'h154
// ----------------------------------------
// fields and values
// ----------------------------------------
`define ISV_NSRC       32
`define ISV_FAST_SRC   0
`define ISV_SMR_MASK   32'h00000067
`define ISV_PRIO_LSB   0
`define ISV_PRIO_W     3
`define ISV_TYPE_LSB   5
`define ISV_TYPE_W     2
`define ISV_ID_W       5
`define ISV_EXT_MASK   32'h00000001
`define ISV_RST_WORD   32'h00000000
`define ISV_EVT_W      2
`define ISV_EVT_SPU    0
`define ISV_EVT_FSPU   1
`define ISV_RESP_OKAY  2'h0
`define ISV_RESP_SLV   2'h2
`endif

// ==== logic/isv_pkg.sv ====
`default_nettype none
package isv_pkg;
   typedef logic [31:0] word_t;
   typedef logic [2:0]  prio_t;
   typedef logic [1:0]  trig_t;
   typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;
   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_t;
endpackage
`default_nettype wire

// ==== logic/interrupt_source_config_and_vectoring.sv ====
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "isv_map_map.svh"
module interrupt_source_config_and_vectoring
   import isv_pkg::*;
(
   input  wire logic                    aclk,          // system clock
   input  wire logic                    aresetn,       // sync reset, low
   input  wire logic [`ISV_ADDR_W-1:0]  awaddr,        // write address
   input  wire logic                    awvalid,       // write address valid
   output logic                         awready,       // write address ready
   input  wire logic [31:0]             wdata,         // write data
   input  wire logic [3:0]              wstrb,         // byte strobes
   input  wire logic                    wvalid,        // write data valid
   output logic                         wready,        // write data ready
   output logic [1:0]                   bresp,         // write response
   output logic                         bvalid,        // write response valid
   input  wire logic                    bready,        // write response ready
   input  wire logic [`ISV_ADDR_W-1:0]  araddr,        // read address
   input  wire logic                    arvalid,       // read address valid
   output logic                         arready,       // read address ready
   output logic [31:0]                  rdata,         // read data
   output logic [1:0]                   rresp,         // read response
   output logic                         rvalid,        // read data valid
   input  wire logic                    rready,        // read data ready
   input  wire logic [`ISV_NSRC-1:0]    src_in,        // raw source lines
   input  wire logic [`ISV_ID_W-1:0]    current_id,    // current source number
   input  wire logic                    current_valid, // a current interrupt exists
   input  wire logic                    fast_active,   // fast interrupt active
   input  wire logic [`ISV_NSRC-1:0]    clear_pending, // clears edge pending
   output logic [`ISV_NSRC-1:0]         pending,       // pending per source
   output logic [3*`ISV_NSRC-1:0]       src_priority,  // priority per source
   output logic [2*`ISV_NSRC-1:0]       trigger_type,  // trigger per source
   output logic                         vector_read,   // current vector read pulse
   output logic                         irq            // event interrupt
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam logic [`ISV_NSRC-1:0] ext_mask = `ISV_EXT_MASK;
   word_t                    mode_reg [`ISV_NSRC], mode_next [`ISV_NSRC];
   word_t                    handler_reg [`ISV_NSRC], handler_next [`ISV_NSRC];
   word_t                    spurious_vector_reg, spurious_vector_next;
   logic [`ISV_ID_W-1:0]     cur_src_reg;
   logic [`ISV_EVT_W-1:0]    evt_reg, evt_next, evm_reg, evm_next;
   logic [`ISV_NSRC-1:0]     src_meta_reg, src_sync_reg, src_prev_reg;
   logic [`ISV_NSRC-1:0]     edge_reg, edge_next, act;
   wr_state_t                wr_state_reg, wr_state_next;
   rd_state_t                rd_state_reg, rd_state_next;
   logic                     aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic [`ISV_ADDR_W-1:0]   waddr_reg, waddr_next;
   word_t                    wdat_reg, wdat_next;
   logic [3:0]               wstb_reg, wstb_next;
   logic [1:0]               bresp_reg, bresp_next, rresp_reg, rresp_next;
   word_t                    rdata_reg, rdata_next;
   logic                     vread_reg, vread_next;
   logic [`ISV_EVT_W-1:0]    evt_set, evt_clr;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic in_bank(input logic [`ISV_ADDR_W-1:0] a, input logic [4:0] bank);
      in_bank = (a[`ISV_BANK_MSB:`ISV_BANK_LSB] == bank);
   endfunction
   function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction

   // ----------------------------------------
   // source synchronisers and pending
   // ----------------------------------------
   // per-source polarity, edge latch and outward fields
   for (genvar i = 0; i < `ISV_NSRC; i++) begin : g_src
      trig_t trig;
      logic  inv, act_prev;
      assign trig     = mode_reg[i][`ISV_TYPE_LSB +: `ISV_TYPE_W];
      assign inv      = ext_mask[i] & ~trig[1];
      assign act[i]   = src_sync_reg[i] ^ inv;
      assign act_prev = src_prev_reg[i] ^ inv;
      // set wins over clear
      assign edge_next[i] = trig[0] & ((act[i] & ~act_prev) | (edge_reg[i] & ~clear_pending[i]));
      assign pending[i]   = trig[0] ? edge_reg[i] : act[i];
      assign trigger_type[i*2 +: 2] = trig;
      if (i == `ISV_FAST_SRC) begin : g_fast
         assign src_priority[i*3 +: 3] = '0;
      end else begin : g_norm
         assign src_priority[i*3 +: 3] = mode_reg[i][`ISV_PRIO_LSB +: `ISV_PRIO_W];
      end
   end

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   assign awready = (wr_state_reg == WR_IDLE) && !aw_held_reg;
   assign wready  = (wr_state_reg == WR_IDLE) && !w_held_reg;
   assign bvalid  = (wr_state_reg == WR_RESP);
   assign bresp   = bresp_reg;

   // capture address and data in any order, then commit
   always_comb begin
      wr_state_next        = wr_state_reg;
      aw_held_next         = aw_held_reg;
      w_held_next          = w_held_reg;
      waddr_next           = waddr_reg;
      wdat_next            = wdat_reg;
      wstb_next            = wstb_reg;
      bresp_next           = bresp_reg;
      spurious_vector_next = spurious_vector_reg;
      evm_next             = evm_reg;
      evt_clr              = '0;
      for (int k = 0; k < `ISV_NSRC; k++) begin
         mode_next[k]    = mode_reg[k];
         handler_next[k] = handler_reg[k];
      end
      unique case (wr_state_reg)
         WR_IDLE: begin
            if (aw_held_reg && w_held_reg) begin
               bresp_next = `ISV_RESP_OKAY;
               if (in_bank(waddr_reg, `ISV_SMR_BANK)) begin
                  mode_next[waddr_reg[`ISV_IDX_MSB:`ISV_IDX_LSB]] =
                     merge(mode_reg[waddr_reg[`ISV_IDX_MSB:`ISV_IDX_LSB]], wdat_reg, wstb_reg) & `ISV_SMR_MASK;
               end else if (in_bank(waddr_reg, `ISV_SVR_BANK)) begin
                  handler_next[waddr_reg[`ISV_IDX_MSB:`ISV_IDX_LSB]] =
                     merge(handler_reg[waddr_reg[`ISV_IDX_MSB:`ISV_IDX_LSB]], wdat_reg, wstb_reg);
               end else if (waddr_reg == `ISV_SPU_OFF) begin
                  spurious_vector_next = merge(spurious_vector_reg, wdat_reg, wstb_reg);
               end else if (waddr_reg == `ISV_EVT_OFF) begin
                  evt_clr = wstb_reg[0] ? wdat_reg[`ISV_EVT_W-1:0] : '0;
               end else if (waddr_reg == `ISV_EVM_OFF) begin
                  evm_next = wstb_reg[0] ? wdat_reg[`ISV_EVT_W-1:0] : evm_reg;
               end else begin
                  bresp_next = `ISV_RESP_SLV;                           // read-only or unmapped
               end
               aw_held_next  = 1'b0;
               w_held_next   = 1'b0;
               wr_state_next = WR_RESP;
            end else begin
               if (awvalid && !aw_held_reg) begin
                  aw_held_next = 1'b1;
                  waddr_next   = awaddr;
               end
               if (wvalid && !w_held_reg) begin
                  w_held_next = 1'b1;
                  wdat_next   = wdata;
                  wstb_next   = wstrb;
               end
            end
         end
         WR_RESP: begin
            if (bready) begin
               wr_state_next = WR_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   assign arready     = (rd_state_reg == RD_IDLE);
   assign rvalid      = (rd_state_reg == RD_DATA);
   assign rdata       = rdata_reg;
   assign rresp       = rresp_reg;
   assign vector_read = vread_reg;

   // decode and sample the read at acceptance
   always_comb begin
      rd_state_next = rd_state_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      vread_next    = 1'b0;
      evt_set       = '0;
      unique case (rd_state_reg)
         RD_IDLE: begin
            if (arvalid) begin
               rd_state_next = RD_DATA;
               rresp_next    = `ISV_RESP_OKAY;
               rdata_next    = `ISV_RST_WORD;
               if (in_bank(araddr, `ISV_SMR_BANK)) begin
                  rdata_next = mode_reg[araddr[`ISV_IDX_MSB:`ISV_IDX_LSB]];
               end else if (in_bank(araddr, `ISV_SVR_BANK)) begin
                  rdata_next = handler_reg[araddr[`ISV_IDX_MSB:`ISV_IDX_LSB]];
               end else if (araddr == `ISV_IVR_OFF) begin
                  vread_next = 1'b1;
                  if (current_valid) begin
                     rdata_next = handler_reg[current_id];
                  end else begin
                     rdata_next = spurious_vector_reg;
                     evt_set[`ISV_EVT_SPU] = 1'b1;
                  end
               end else if (araddr == `ISV_FVR_OFF) begin
                  if (fast_active) begin
                     rdata_next = handler_reg[`ISV_FAST_SRC];
                  end else begin
                     rdata_next = spurious_vector_reg;
                     evt_set[`ISV_EVT_FSPU] = 1'b1;
                  end
               end else if (araddr == `ISV_ISR_OFF) begin
                  rdata_next[`ISV_ID_W-1:0] = cur_src_reg;
               end else if (araddr == `ISV_IPR_OFF) begin
                  rdata_next = pending;
               end else if (araddr == `ISV_SPU_OFF) begin
                  rdata_next = spurious_vector_reg;
               end else if (araddr == `ISV_EVT_OFF) begin
                  rdata_next[`ISV_EVT_W-1:0] = evt_reg;
               end else if (araddr == `ISV_EVM_OFF) begin
                  rdata_next[`ISV_EVT_W-1:0] = evm_reg;
               end else begin
                  rresp_next = `ISV_RESP_SLV;
               end
            end
         end
         RD_DATA: begin
            if (rready) begin
               rd_state_next = RD_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------
   // events and interrupt
   // ----------------------------------------
   // sticky, write one to clear, set wins
   assign evt_next = (evt_reg & ~evt_clr) | evt_set;
   assign irq      = |(evt_reg & evm_reg);
   // ----------------------------------------
   // register update
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < `ISV_NSRC; k++) begin
            mode_reg[k]    <= `ISV_RST_WORD;
            handler_reg[k] <= `ISV_RST_WORD;
         end
         spurious_vector_reg <= `ISV_RST_WORD;
         src_meta_reg <= '0;
         src_sync_reg <= '0;
         src_prev_reg <= '0;
         edge_reg     <= '0;
         cur_src_reg  <= '0;
         evt_reg      <= '0;
         evm_reg      <= '0;
         wr_state_reg <= WR_IDLE;
         rd_state_reg <= RD_IDLE;
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         bresp_reg    <= `ISV_RESP_OKAY;
         rresp_reg    <= `ISV_RESP_OKAY;
         rdata_reg    <= `ISV_RST_WORD;
         vread_reg    <= 1'b0;
      end else begin
         for (int k = 0; k < `ISV_NSRC; k++) begin
            mode_reg[k]    <= mode_next[k];
            handler_reg[k] <= handler_next[k];
         end
         spurious_vector_reg <= spurious_vector_next;
         src_meta_reg <= src_in;                                         // two flops, then edge history
         src_sync_reg <= src_meta_reg;
         src_prev_reg <= src_sync_reg;
         edge_reg     <= edge_next;
         cur_src_reg  <= current_valid ? current_id : cur_src_reg;
         evt_reg      <= evt_next;
         evm_reg      <= evm_next;
         wr_state_reg <= wr_state_next;
         rd_state_reg <= rd_state_next;
         aw_held_reg  <= aw_held_next;
         w_held_reg   <= w_held_next;
         waddr_reg    <= waddr_next;
         wdat_reg     <= wdat_next;
         wstb_reg     <= wstb_next;
         bresp_reg    <= bresp_next;
         rresp_reg    <= rresp_next;
         rdata_reg    <= rdata_next;
         vread_reg    <= vread_next;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic  rd_ivr, rd_fvr, rd_isr;
   assign rd_ivr   = arvalid && arready && (araddr == `ISV_IVR_OFF);
   assign rd_fvr   = arvalid && arready && (araddr == `ISV_FVR_OFF);
   assign rd_isr   = arvalid && arready && (araddr == `ISV_ISR_OFF);
   a_prio_range: assert property (src_priority[5:3] == mode_reg[1][2:0])
      else $error("source 1 priority does not follow its mode register");
   a_fast_prio_zero: assert property (src_priority[2:0] == 3'h0)
      else $error("fast source priority not ignored");
   a_fast_prio_hold: assert property ($changed(mode_reg[0]) |-> src_priority[2:0] == 3'h0)
      else $error("fast source priority leaked on mode change");
   a_edge_internal: assert property (mode_reg[1][6:5] == 2'b01 && src_sync_reg[1] && !src_prev_reg[1]
      |=> pending[1])
      else $error("internal rising edge did not set pending");
   a_ext_low_level: assert property (mode_reg[0][6:5] == 2'b00 |-> pending[0] == !src_sync_reg[0])
      else $error("external low level not reported");
   a_handler_reset: assert property ($past(!aresetn) |-> handler_reg[3] == 32'h00000000)
      else $error("handler register not zero after reset");
   a_ivr_current: assert property (rd_ivr && current_valid |=>
      rvalid && rdata == $past(handler_reg[current_id]))
      else $error("current vector read wrong handler");
   a_ivr_spurious: assert property (rd_ivr && !current_valid |=> rdata == $past(spurious_vector_reg))
      else $error("spurious vector not returned");
   a_fvr_value: assert property (rd_fvr |=> rdata ==
      ($past(fast_active) ? $past(handler_reg[0]) : $past(spurious_vector_reg)))
      else $error("fast vector read wrong value");
   a_isr_width: assert property (rd_isr |=> rdata[31:5] == 27'h0 && rdata[4:0] == $past(cur_src_reg))
      else $error("current source read wrong");
   a_pend_level: assert property (mode_reg[2][6:5] == 2'b10 |-> pending[2] == src_sync_reg[2])
      else $error("high level pending wrong");
   a_write_resp: assert property (aw_held_reg && w_held_reg && wr_state_reg == WR_IDLE |=> bvalid [*1])
      else $error("write response late");

   c_ivr_hit: cover property (rd_ivr && current_valid);
   c_ivr_spur: cover property (rd_ivr && !current_valid);
   c_edge_seen: cover property (edge_reg[1] ##1 clear_pending[1]);
   c_irq_up: cover property ($rose(irq));
endmodule
`default_nettype wire

// ==== tb/core_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
   input  wire logic        aclk,          // system clock
   input  wire logic        aresetn,       // sync reset, low
   input  wire logic [31:0] want_src,      // wanted source levels
   input  wire logic [4:0]  want_id,       // wanted current number
   input  wire logic        want_valid,    // wanted current flag
   input  wire logic        want_fast,     // wanted fast flag
   input  wire logic [31:0] want_clr,      // wanted pending clears
   output logic      [31:0] src_in,        // source lines
   output logic      [4:0]  current_id,    // current number
   output logic             current_valid, // current exists
   output logic             fast_active,   // fast in service
   output logic      [31:0] clear_pending  // pending clears
);
   // ---------------------------------
   // registered far side, one edge late
   // ---------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {src_in, current_id, current_valid, fast_active, clear_pending} <= '0;
      end else begin
         {src_in, current_id, current_valid} <= {want_src, want_id, want_valid};
         {fast_active, clear_pending}        <= {want_fast, want_clr};
      end
   end
endmodule
`default_nettype wire

// ==== tb/interrupt_source_config_and_vectoring_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isv_map_map.svh"
module interrupt_source_config_and_vectoring_tb_top;
   import isv_pkg::*;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, vector_read, irq, current_valid, fast_active;
   logic        want_valid, want_fast, vr;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, src_in, clear_pending, pending, want_src, want_clr;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [4:0]  current_id, want_id, id;
   logic [95:0] src_priority;
   logic [63:0] trigger_type;
   word_t       h [32];
   word_t       d, e, spu;
   int          seed, i, c, s, k, miscompares, total_checks;
   interrupt_source_config_and_vectoring interrupt_source_config_and_vectoring_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .src_in(src_in), .current_id(current_id),
      .current_valid(current_valid), .fast_active(fast_active), .clear_pending(clear_pending),
      .pending(pending), .src_priority(src_priority), .trigger_type(trigger_type),
      .vector_read(vector_read), .irq(irq));
   core_side_model core_side_model_inst (
      .aclk(aclk), .aresetn(aresetn), .want_src(want_src), .want_id(want_id), .want_valid(want_valid),
      .want_fast(want_fast), .want_clr(want_clr), .src_in(src_in), .current_id(current_id),
      .current_valid(current_valid), .fast_active(fast_active), .clear_pending(clear_pending));
   // ---------------------------------
   // clock and helpers
   // ---------------------------------
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   function automatic logic act(int s, int c); // active level of a source
      return (s == 0) ? c[1] : 1'b1;
   endfunction
   task automatic chk(input string nm, input word_t seen, input word_t exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bound(input int n);
      if (n >= 100) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   // ---------------------------------
   // bus master tasks
   // ---------------------------------
   task automatic wr(input logic [11:0] a, input word_t v, output logic [1:0] rs);
      int   n;
      logic ha, hw, hb;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         {ha, hw, hb, rs} = {awvalid && awready, wvalid && wready, bvalid, bresp};
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
      bound(n);
   endtask
   task automatic rd(input logic [11:0] a, output word_t v, output logic [1:0] rs);
      int   n;
      logic ha, hr;
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         {ha, hr, v, rs, vr} = {arvalid && arready, rvalid, rdata, rresp, vector_read};
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) break;
      end
      rready <= 1'b0;
      bound(n);
   endtask
   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      seed = 32'hA036E31C;
      {awvalid, wvalid, bready, arvalid, rready, want_valid, want_fast} = '0;
      {awaddr, araddr, wdata, want_id, want_src, want_clr} = '0;
      {wstrb, aresetn, miscompares, total_checks} = {4'hF, 1'b0, 64'h0};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h000, d, r);
      chk("mode reset", d, 32'h0);
      rd(12'h0FC, d, r);
      chk("handler reset", d, 32'h0);
      rd(12'h108, d, r);
      chk("source reg reset", d, 32'h0);
      $display("test reset done");
      // mode and handler registers, random words
      for (i = 0; i < 32; i++) begin
         d = $random(seed);
         wr(12'(4 * i), d, r);
         rd(12'(4 * i), e, r);
         chk("mode", e, d & `ISV_SMR_MASK);
         chk("prio", 32'(src_priority[3*i+:3]), (i == 0) ? 32'h0 : 32'(d[2:0]));
         chk("type", 32'(trigger_type[2*i+:2]), 32'(d[6:5]));
         h[i] = $random(seed);
         wr(12'h080 + 12'(4 * i), h[i], r);
         rd(12'h080 + 12'(4 * i), d, r);
         chk("handler", d, h[i]);
      end
      $display("test registers done");
      // spurious vector, event interrupt, current vectors
      spu = $random(seed);
      wr(12'h134, spu, r);
      wr(12'h154, 32'h3, r);
      rd(12'h100, d, r);
      chk("vector none", d, spu);
      chk("irq set", 32'(irq), 32'h1);
      wr(12'h150, 32'h1, r);
      chk("irq clear", 32'(irq), 32'h0);
      for (k = 0; k < 8; k++) begin
         id = (k == 0) ? 5'h1F : 5'($random(seed));
         {want_id, want_valid} <= {id, 1'b1};
         repeat (2) @(posedge aclk);
         rd(12'h100, d, r);
         chk("vector cur", d, h[id]);
         chk("vector pulse", 32'(vr), 32'h1);
         rd(12'h108, d, r);
         chk("source reg", d, 32'(id));
         chk("pulse idle", 32'(vr), 32'h0);
      end
      want_valid <= 1'b0;
      rd(12'h104, d, r);
      chk("fast none", d, spu);
      rd(12'h150, d, r);
      chk("fast event", d, 32'h2);
      want_fast <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(12'h104, d, r);
      chk("fast vector", d, h[0]);
      $display("test vectors done");
      // trigger codes on fast source 0 and internal sources 1, 2 and 5
      for (s = 0; s < 6; s += (s < 2) ? 1 : 3) begin
         for (c = 0; c < 4; c++) begin
            wr(12'(4 * s), 32'(c) << 5, r);
            want_src[s] <= ~act(s, c);
            repeat (5) @(posedge aclk);
            want_clr[s] <= 1'b1;
            @(posedge aclk);
            want_clr[s] <= 1'b0;
            repeat (3) @(posedge aclk);
            chk("pend idle", 32'(pending[s]), 32'h0);
            want_src[s] <= act(s, c);
            repeat (5) @(posedge aclk);
            chk("pend active", 32'(pending[s]), 32'h1);
            rd(12'h10C, d, r);
            chk("pend reg", (d >> s) & 32'h1, 32'h1);
            want_src[s] <= ~act(s, c);
            repeat (5) @(posedge aclk);
            chk("pend after", 32'(pending[s]), 32'(c[0]));
            want_clr[s] <= 1'b1;
            @(posedge aclk);
            want_clr[s] <= 1'b0;
            repeat (3) @(posedge aclk);
            chk("pend cleared", 32'(pending[s]), 32'h0);
         end
      end
      $display("test pending done");
      rd(12'h200, d, r);
      chk("unmapped data", d, 32'h0);
      chk("unmapped resp", 32'(r), 32'(`ISV_RESP_SLV));
      wr(12'h100, 32'h1, r);
      chk("read only resp", 32'(r), 32'(`ISV_RESP_SLV));
      $display("test errors done");
      report_and_stop();
   end
endmodule
`default_nettype wire
